// >>> sfi_host_model.sv
// Behavioural multi-lane SPI host that frames identification reads.
// Assumes clk_sys runs sixteen times faster than the serial clock.
`timescale 1ns/1ps
module sfi_host_model (
  input  wire logic       clk_sys,
  output logic            cs_n,
  output logic            sck,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic [11:0] got_w;
  event        got_ev;

  // Idle: chip select high and the serial clock parked low.
  initial begin
    cs_n = 1'h1;
    sck = 1'h0;
    io_in = 4'h0;
  end

  // One serial clock; data set while low, lanes read just before the rise.
  task automatic cyc(input logic [3:0] d, output logic [3:0] q);
    @(posedge clk_sys);
    io_in <= d;
    repeat (7) @(posedge clk_sys);
    q = io_out;
    got_w[11:8] = io_oe;
    sck <= 1'h1;
    repeat (8) @(posedge clk_sys);
    sck <= 1'h0;
  endtask : cyc

  // Opcode, address and mode, dummies, then nb bytes read ow bits a clock.
  // Lanes the host does not own carry noise, never a held value.
  task automatic frame(input logic [7:0] op, input logic qpi, input int aw,
                       input int an, input logic [31:0] av, input int dn,
                       input int ow, input int nb);
    logic [3:0] q;
    logic [3:0] m;
    logic [7:0] b;
    logic [31:0] a;
    a = av;
    m = 4'hF << aw;
    @(posedge clk_sys);
    cs_n <= 1'h0;
    repeat (4) @(posedge clk_sys);
    if (qpi) begin
      cyc(op[7:4], q);
      cyc(op[3:0], q);
    end else begin
      for (int i = 7; i >= 0; i--) cyc({3'($urandom), op[i]}, q);
    end
    for (int i = 0; i < an; i++) begin
      cyc((a[31:28] >> (4 - aw)) | (m & 4'($urandom)), q);
      a = a << aw;
    end
    for (int i = 0; i < dn; i++) cyc(4'($urandom), q);
    for (int k = 0; k < nb; k++) begin
      b = 8'h00;
      for (int i = 0; i < 8 / ow; i++) begin
        cyc(4'($urandom), q);
        q = (ow == 1) ? {3'h0, q[1]} : (ow == 2) ? {2'h0, q[1:0]} : q;
        b = (b << ow) | 8'(q);
      end
      got_w[7:0] = b;
      ->got_ev;
    end
    @(posedge clk_sys);
    cs_n <= 1'h1;
    repeat (8) @(posedge clk_sys);
  endtask : frame
endmodule : sfi_host_model

// >>> sfi_id_readout.sv
// Identification-read instruction decoder and responder of a serial flash.
// Assumes the host drives cs_n and sck; both are sampled by clk_sys, which
// must run at least eight times faster than sck.
// Behaviour
// - Dual ID: 92h, address and mode two-bit
// - Dual ID output two bits, MSB first
// - Address 000001h swaps order; bytes alternate
// - Quad ID: 94h, four-bit address, four dummies
// - Quad ID output four bits, MSB first
// - Unique ID: 4Bh, 32 dummies, 64 bits
// - Unique number is fixed, read-only
// - 9Fh outputs maker, type, capacity bytes
// - 5Ah, address, eight dummies, output at 40
// - Low address byte selects table start
// - Signature, revisions and header count bytes
// - Byte 07h FFh, ID and minor zero
// - Dual and quad ID only in SPI
// - Power-down ignores all these reads
`timescale 1ns/1ps
module sfi_id_readout #(
  parameter logic [7:0]  MFR_ID    = 8'h5A, // Arbitrary value.
  parameter logic [7:0]  DEVICE_ID = 8'h13, // Arbitrary value.
  parameter logic [7:0]  MEM_TYPE  = 8'h40, // Arbitrary value.
  parameter logic [7:0]  CAPACITY  = 8'h14, // Arbitrary value.
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF // Arbitrary.
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  input  wire logic       power_down,
  input  wire logic       qpi_mode
);

  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic       sck_s3_q;
  logic       cs_n_s;
  logic       sck_s;
  logic [3:0] io_s;
  logic       sck_rise;
  logic       sck_fall;

  sfi_pkg::sfi_state_t st_q, st_d;
  sfi_pkg::sfi_kind_t  kind_q, kind_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [5:0]  len_q, len_d;
  logic [2:0]  w_q, w_d;
  logic [31:0] in_q, in_d;
  logic [63:0] sr_q, sr_d;
  logic [6:0]  rem_q, rem_d;
  logic        swap_q, swap_d;
  logic [7:0]  ptr_q, ptr_d;
  logic [3:0]  out_d, oe_d;
  logic [7:0]  rom_data;
  logic [31:0] shifted;
  logic [63:0] unit;
  logic [63:0] cur;
  logic [6:0]  unit_len;
  logic [6:0]  cur_rem;
  logic [7:0]  op;

  // Reset release through two flops so that every flop leaves reset together.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Two-flop synchronisers for the pins, plus one more sck stage for edges.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 6'h01;
      pin_s2_q <= 6'h01;
      sck_s3_q <= 1'h0;
    end else begin
      pin_s1_q <= {io_in, sck, cs_n};
      pin_s2_q <= pin_s1_q;
      sck_s3_q <= pin_s2_q[1];
    end
  end
  assign cs_n_s   = pin_s2_q[0];
  assign sck_s    = pin_s2_q[1];
  assign io_s     = pin_s2_q[5:2];
  assign sck_rise = sck_s & ~sck_s3_q;
  assign sck_fall = ~sck_s & sck_s3_q;

  sfi_table_rom u_rom (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .addr    (ptr_q),
    .rdata   (rom_data)
  );

  // Input shift by the current lane width.
  always_comb begin
    case (w_q)
      sfi_pkg::SFI_W2: shifted = {in_q[29:0], io_s[1:0]};
      sfi_pkg::SFI_W4: shifted = {in_q[27:0], io_s};
      default:         shifted = {in_q[30:0], io_s[0]};
    endcase
  end
  assign op = shifted[7:0];

  // Next output unit, left aligned; ID units repeat while clocks go on, table bytes advance.
  always_comb begin
    case (kind_q)
      sfi_pkg::SFI_K_MD: begin
        unit     = swap_q ? {DEVICE_ID, MFR_ID, 48'h0}
                          : {MFR_ID, DEVICE_ID, 48'h0};
        unit_len = sfi_pkg::SFI_MD_BITS;
      end
      sfi_pkg::SFI_K_JEDEC: begin
        unit     = {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
        unit_len = sfi_pkg::SFI_JEDEC_BITS;
      end
      sfi_pkg::SFI_K_UID: begin
        unit     = UNIQUE_ID; // Constant: no instruction writes it.
        unit_len = sfi_pkg::SFI_UID_BITS;
      end
      default: begin
        unit     = {rom_data, 56'h0};
        unit_len = sfi_pkg::SFI_SFDP_BITS;
      end
    endcase
    cur     = (rem_q == 7'h00) ? unit : sr_q;
    cur_rem = (rem_q == 7'h00) ? unit_len : rem_q;
  end

  // Instruction sequencer; it restarts whenever chip select goes high.
  always_comb begin
    st_d   = st_q;
    kind_d = kind_q;
    cnt_d  = cnt_q;
    len_d  = len_q;
    w_d    = w_q;
    in_d   = in_q;
    sr_d   = sr_q;
    rem_d  = rem_q;
    swap_d = swap_q;
    ptr_d  = ptr_q;
    out_d  = io_out;
    oe_d   = io_oe;
    if (cs_n_s) begin
      st_d  = sfi_pkg::SFI_ST_CMD;
      cnt_d = 6'h00;
      len_d = qpi_mode ? sfi_pkg::SFI_CMD_CLKS_QPI
                       : sfi_pkg::SFI_CMD_CLKS_SPI;
      w_d   = qpi_mode ? sfi_pkg::SFI_W4 : sfi_pkg::SFI_W1;
      in_d  = sfi_pkg::SFI_IN_RST;
      rem_d = 7'h00;
      oe_d  = 4'h0;
      out_d = 4'h0;
    end else begin
      case (st_q)
        sfi_pkg::SFI_ST_CMD, sfi_pkg::SFI_ST_ADDR,
        sfi_pkg::SFI_ST_DUMMY: begin
          if (sck_rise) begin
            in_d  = shifted;
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == len_q - 6'h01) begin
              cnt_d = 6'h00;
              if (st_q == sfi_pkg::SFI_ST_CMD) begin
                if (power_down) begin
                  st_d = sfi_pkg::SFI_ST_IGNORE;
                end else if (op == sfi_pkg::SFI_OP_JEDEC) begin
                  kind_d = sfi_pkg::SFI_K_JEDEC;
                  st_d   = sfi_pkg::SFI_ST_OUT;
                end else if (qpi_mode) begin
                  st_d = sfi_pkg::SFI_ST_IGNORE;
                end else if (op == sfi_pkg::SFI_OP_DUAL_ID) begin
                  kind_d = sfi_pkg::SFI_K_MD;
                  st_d   = sfi_pkg::SFI_ST_ADDR;
                  len_d  = sfi_pkg::SFI_DUAL_ADDR_CLKS;
                  w_d    = sfi_pkg::SFI_W2;
                end else if (op == sfi_pkg::SFI_OP_QUAD_ID) begin
                  kind_d = sfi_pkg::SFI_K_MD;
                  st_d   = sfi_pkg::SFI_ST_ADDR;
                  len_d  = sfi_pkg::SFI_QUAD_ADDR_CLKS;
                  w_d    = sfi_pkg::SFI_W4;
                end else if (op == sfi_pkg::SFI_OP_UID) begin
                  kind_d = sfi_pkg::SFI_K_UID;
                  st_d   = sfi_pkg::SFI_ST_DUMMY;
                  len_d  = sfi_pkg::SFI_UID_DUMMY;
                end else if (op == sfi_pkg::SFI_OP_SFDP) begin
                  kind_d = sfi_pkg::SFI_K_SFDP;
                  st_d   = sfi_pkg::SFI_ST_ADDR;
                  len_d  = sfi_pkg::SFI_SFDP_ADDR_CLKS;
                end else begin
                  st_d = sfi_pkg::SFI_ST_IGNORE;
                end
              end else if (st_q == sfi_pkg::SFI_ST_ADDR) begin
                if (kind_q == sfi_pkg::SFI_K_SFDP) begin
                  ptr_d = shifted[7:0]; // Bits 23..8 unused.
                  st_d  = sfi_pkg::SFI_ST_DUMMY;
                  len_d = sfi_pkg::SFI_SFDP_DUMMY;
                end else begin
                  // Mode bits in shifted[7:0] are not acted on.
                  swap_d = shifted[8];
                  if (w_q == sfi_pkg::SFI_W4) begin
                    st_d  = sfi_pkg::SFI_ST_DUMMY;
                    len_d = sfi_pkg::SFI_QUAD_DUMMY;
                  end else begin
                    st_d = sfi_pkg::SFI_ST_OUT;
                  end
                end
              end else begin
                st_d = sfi_pkg::SFI_ST_OUT;
              end
            end
          end
        end
        sfi_pkg::SFI_ST_OUT: begin
          // Data change on falling sck edges, most significant first.
          if (sck_fall) begin
            sr_d  = cur << w_q;
            rem_d = cur_rem - {4'h0, w_q};
            if (rem_q == 7'h00 && kind_q == sfi_pkg::SFI_K_SFDP) begin
              ptr_d = ptr_q + 8'h01; // Wraps within the table.
            end
            case (w_q)
              sfi_pkg::SFI_W2: begin
                out_d = {2'h0, cur[63:62]};
                oe_d  = 4'h3;
              end
              sfi_pkg::SFI_W4: begin
                out_d = cur[63:60];
                oe_d  = 4'hF;
              end
              default: begin
                out_d = {2'h0, cur[63], 1'h0};
                oe_d  = 4'h2;
              end
            endcase
          end
        end
        default: begin
          st_d = sfi_pkg::SFI_ST_IGNORE;
        end
      endcase
    end
  end

  // Sequencer and output state registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= sfi_pkg::SFI_ST_CMD;
      kind_q <= sfi_pkg::SFI_K_MD;
      cnt_q  <= 6'h00;
      len_q  <= sfi_pkg::SFI_CMD_CLKS_SPI;
      w_q    <= sfi_pkg::SFI_W1;
      in_q   <= sfi_pkg::SFI_IN_RST;
      sr_q   <= sfi_pkg::SFI_SR_RST;
      rem_q  <= 7'h00;
      swap_q <= 1'h0;
      ptr_q  <= sfi_pkg::SFI_PTR_RST;
      io_out <= 4'h0;
      io_oe  <= 4'h0;
    end else begin
      st_q   <= st_d;
      kind_q <= kind_d;
      cnt_q  <= cnt_d;
      len_q  <= len_d;
      w_q    <= w_d;
      in_q   <= in_d;
      sr_q   <= sr_d;
      rem_q  <= rem_d;
      swap_q <= swap_d;
      ptr_q  <= ptr_d;
      io_out <= out_d;
      io_oe  <= oe_d;
    end
  end

endmodule : sfi_id_readout

// >>> sfi_id_readout_assertions.sv
// Port-level checks for the identification readout.
// Assumes the host keeps qpi_mode and power_down steady within frames.
`timescale 1ns/1ps
module sfi_id_readout_assertions (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic       power_down,
  input wire logic       qpi_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Lanes are quiet when reset lets go.
  rst_quiet_a: assert property ($rose(nrst) |->
    io_oe == 4'h0 && io_out == 4'h0)
    else $error("outputs active after reset");
  // Only the single, dual and quad lane patterns are ever driven.
  oe_legal_a: assert property (io_oe inside {4'h0, 4'h2,
    4'h3, 4'hF})
    else $error("illegal lane enable pattern");
  // Data moves only while the serial clock is low, after its falling edge.
  out_fall_a: assert property ($changed(io_out) |-> !sck)
    else $error("output changed while clock high");
  // Dual lanes never open in two-clock quad instruction mode.
  dual_spi_a: assert property (io_oe == 4'h3 |-> !qpi_mode)
    else $error("dual output in quad instruction mode");
  // A powered-down device stays silent.
  pd_silent_a: assert property (power_down [*8] |-> io_oe == 4'h0)
    else $error("output while powered down");
  // Releasing chip select frees the lanes within a few cycles.
  cs_release_a: assert property ($rose(cs_n) |->
    ##[1:6] io_oe == 4'h0)
    else $error("lanes held after chip select rose");
  // Lanes are driven only inside a frame.
  oe_frame_a: assert property (io_oe != 4'h0 |-> !$past(cs_n, 6))
    else $error("lanes driven outside a frame");
  // A long idle period keeps every lane released.
  idle_quiet_a: assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("lanes driven while idle");

  single_c: cover property (io_oe == 4'h2);
  dual_c: cover property (io_oe == 4'h3);
  quad_c: cover property (io_oe == 4'hF);
endmodule : sfi_id_readout_assertions

// >>> sfi_pkg.sv
// Shared constants and types for the serial flash identification readout.
// Assumes a one-lane or multi-lane SPI host drives chip select and clock.
package sfi_pkg;

  // Instruction codes handled by this block.
  localparam logic [7:0] SFI_OP_DUAL_ID = 8'h92;
  localparam logic [7:0] SFI_OP_QUAD_ID = 8'h94;
  localparam logic [7:0] SFI_OP_UID     = 8'h4B;
  localparam logic [7:0] SFI_OP_JEDEC   = 8'h9F;
  localparam logic [7:0] SFI_OP_SFDP    = 8'h5A;

  // Clock counts of each phase, in serial clock rising edges.
  localparam logic [5:0] SFI_CMD_CLKS_SPI   = 6'h08;
  localparam logic [5:0] SFI_CMD_CLKS_QPI   = 6'h02;
  localparam logic [5:0] SFI_DUAL_ADDR_CLKS = 6'h10;
  localparam logic [5:0] SFI_QUAD_ADDR_CLKS = 6'h08;
  localparam logic [5:0] SFI_QUAD_DUMMY     = 6'h04;
  localparam logic [5:0] SFI_UID_DUMMY      = 6'h20;
  localparam logic [5:0] SFI_SFDP_ADDR_CLKS = 6'h18;
  localparam logic [5:0] SFI_SFDP_DUMMY     = 6'h08;

  // Lane widths, in bits per serial clock.
  localparam logic [2:0] SFI_W1 = 3'h1;
  localparam logic [2:0] SFI_W2 = 3'h2;
  localparam logic [2:0] SFI_W4 = 3'h4;

  // Length of one repeating output unit, in bits.
  localparam logic [6:0] SFI_MD_BITS    = 7'h10;
  localparam logic [6:0] SFI_JEDEC_BITS = 7'h18;
  localparam logic [6:0] SFI_UID_BITS   = 7'h40;
  localparam logic [6:0] SFI_SFDP_BITS  = 7'h08;

  // Parameter table offsets and contents.
  localparam logic [7:0] SFI_T_SIG0   = 8'h00;
  localparam logic [7:0] SFI_T_SIG1   = 8'h01;
  localparam logic [7:0] SFI_T_SIG2   = 8'h02;
  localparam logic [7:0] SFI_T_SIG3   = 8'h03;
  localparam logic [7:0] SFI_T_MINOR  = 8'h04;
  localparam logic [7:0] SFI_T_MAJOR  = 8'h05;
  localparam logic [7:0] SFI_T_HDRCNT = 8'h06;
  localparam logic [7:0] SFI_T_RSVD   = 8'h07;
  localparam logic [7:0] SFI_T_HDRID  = 8'h08;
  localparam logic [7:0] SFI_T_PMINOR = 8'h09;
  localparam logic [7:0] SFI_V_SIG0   = 8'h53;
  localparam logic [7:0] SFI_V_SIG1   = 8'h46;
  localparam logic [7:0] SFI_V_SIG2   = 8'h44;
  localparam logic [7:0] SFI_V_SIG3   = 8'h50;
  localparam logic [7:0] SFI_V_MINOR  = 8'h00;
  localparam logic [7:0] SFI_V_MAJOR  = 8'h01;
  localparam logic [7:0] SFI_V_HDRCNT = 8'h00;
  localparam logic [7:0] SFI_V_RSVD   = 8'hFF;
  localparam logic [7:0] SFI_V_HDRID  = 8'h00;
  localparam logic [7:0] SFI_V_PMINOR = 8'h00;
  localparam logic [7:0] SFI_V_UNDEF  = 8'hFF;

  // Values after reset.
  localparam logic [63:0] SFI_SR_RST  = 64'h0;
  localparam logic [31:0] SFI_IN_RST  = 32'h0;
  localparam logic [7:0]  SFI_PTR_RST = 8'h00;

  typedef enum logic [2:0] {
    SFI_ST_CMD,
    SFI_ST_ADDR,
    SFI_ST_DUMMY,
    SFI_ST_OUT,
    SFI_ST_IGNORE
  } sfi_state_t;

  typedef enum logic [1:0] {
    SFI_K_MD,
    SFI_K_JEDEC,
    SFI_K_UID,
    SFI_K_SFDP
  } sfi_kind_t;

endpackage : sfi_pkg

// >>> sfi_table_rom.sv
// Read-only discoverable parameter table, 256 bytes.
// Assumes the reader allows one clock of latency on the registered data.
`timescale 1ns/1ps
module sfi_table_rom (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  output logic      [7:0] rdata
);

  logic [7:0] rdata_d;

  // Table lookup; byte 07h and bytes from 0Ah upward read as erased.
  always_comb begin
    if (addr == sfi_pkg::SFI_T_SIG0) begin
      rdata_d = sfi_pkg::SFI_V_SIG0;
    end else if (addr == sfi_pkg::SFI_T_SIG1) begin
      rdata_d = sfi_pkg::SFI_V_SIG1;
    end else if (addr == sfi_pkg::SFI_T_SIG2) begin
      rdata_d = sfi_pkg::SFI_V_SIG2;
    end else if (addr == sfi_pkg::SFI_T_SIG3) begin
      rdata_d = sfi_pkg::SFI_V_SIG3;
    end else if (addr == sfi_pkg::SFI_T_MINOR) begin
      rdata_d = sfi_pkg::SFI_V_MINOR;
    end else if (addr == sfi_pkg::SFI_T_MAJOR) begin
      rdata_d = sfi_pkg::SFI_V_MAJOR;
    end else if (addr == sfi_pkg::SFI_T_HDRCNT) begin
      rdata_d = sfi_pkg::SFI_V_HDRCNT;
    end else if (addr == sfi_pkg::SFI_T_RSVD) begin
      rdata_d = sfi_pkg::SFI_V_RSVD;
    end else if (addr == sfi_pkg::SFI_T_HDRID) begin
      rdata_d = sfi_pkg::SFI_V_HDRID;
    end else if (addr == sfi_pkg::SFI_T_PMINOR) begin
      rdata_d = sfi_pkg::SFI_V_PMINOR;
    end else begin
      rdata_d = sfi_pkg::SFI_V_UNDEF;
    end
  end

  // Registered read data.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= sfi_pkg::SFI_V_UNDEF;
    end else begin
      rdata <= rdata_d;
    end
  end

endmodule : sfi_table_rom

// >>> test_sfi_id_readout.sv
// Self-checking bench for the identification readout.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
module test_sfi_id_readout;
  localparam logic [7:0]  MFR = 8'h3C; // Arbitrary value.
  localparam logic [7:0]  DEV = 8'h27; // Arbitrary value.
  localparam logic [7:0]  MTY = 8'h61; // Arbitrary value.
  localparam logic [7:0]  CAP = 8'h15; // Arbitrary value.
  localparam logic [63:0] UID = 64'hF00D_1234_5678_9ABC; // Arbitrary.

  logic        clk_sys = 1'h0;
  logic        nrst = 1'h0;
  logic        cs_n;
  logic        sck;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic        power_down = 1'h0;
  logic        qpi_mode = 1'h0;
  logic [11:0] exp_q[$];
  logic [7:0]  st;
  int          mismatches = 0;
  int          compares = 0;

  sfi_id_readout #(.MFR_ID(MFR), .DEVICE_ID(DEV), .MEM_TYPE(MTY),
                   .CAPACITY(CAP), .UNIQUE_ID(UID)) uut (
    .clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .power_down(power_down),
    .qpi_mode(qpi_mode));

  sfi_host_model u_host (
    .clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));

  // System clock at 100 MHz.
  always #5 clk_sys = ~clk_sys;

  // Expected table contents; unlisted bytes read as erased.
  function automatic logic [7:0] tbl(input logic [7:0] a);
    case (a)
      8'h00: return 8'h53;
      8'h01: return 8'h46;
      8'h02: return 8'h44;
      8'h03: return 8'h50;
      8'h04, 8'h06, 8'h08, 8'h09: return 8'h00;
      8'h05: return 8'h01;
      default: return 8'hFF;
    endcase
  endfunction : tbl

  // Counts one comparison and reports a difference at once.
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  // Notes one expected lane enable and byte.
  task automatic note(input logic [3:0] oe, input logic [7:0] b);
    exp_q.push_back({oe, b});
  endtask : note

  // Prints the verdict; leftover notes count as misses.
  task automatic report_and_stop;
    mismatches += exp_q.size();
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Pairs each byte the host reads with the oldest note. A refused read
  // compares only the enables, since silent lanes carry no defined data.
  initial begin
    logic [11:0] e;
    logic [11:0] g;
    forever begin
      @(u_host.got_ev);
      g = u_host.got_w;
      if (exp_q.size() == 0) begin
        e = 12'hFFF;
      end else begin
        e = exp_q.pop_front();
      end
      if (e[11:8] === 4'h0) g[7:0] = e[7:0];
      check(g, e);
    end
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #600000;
    mismatches++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hD8DE));
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 6; i++) begin
      note(4'h2, (i % 3 == 0) ? MFR : (i % 3 == 1) ? MTY : CAP);
    end
    u_host.frame(8'h9F, 1'h0, 1, 0, 32'h0, 0, 1, 6);
    qpi_mode <= 1'h1;
    note(4'hF, MFR);
    note(4'hF, MTY);
    note(4'hF, CAP);
    u_host.frame(8'h9F, 1'h1, 1, 0, 32'h0, 0, 4, 3);
    // Dual ID, quad ID, unique ID and table reads are all refused in quad instruction mode.
    for (int j = 0; j < 4; j++) begin
      st = (j == 0) ? 8'h92 : (j == 1) ? 8'h94 : (j == 2) ? 8'h4B : 8'h5A;
      note(4'h0, 8'h00);
      note(4'h0, 8'h00);
      u_host.frame(st, 1'h1, 2, 16, 32'h0000_00F0, 0, 2, 2);
    end
    qpi_mode <= 1'h0;
    for (int a0 = 0; a0 < 2; a0++) begin
      for (int k = 0; k < 4; k++) begin
        note(4'h3, ((k % 2) == a0) ? MFR : DEV);
      end
      u_host.frame(8'h92, 1'h0, 2, 16, {23'h0, 1'(a0), 4'hF, 4'($urandom)},
                   0, 2, 4);
      for (int k = 0; k < 4; k++) begin
        note(4'hF, ((k % 2) == a0) ? MFR : DEV);
      end
      u_host.frame(8'h94, 1'h0, 4, 8, {23'h0, 1'(a0), 4'hF, 4'($urandom)},
                   4, 4, 4);
    end
    for (int r = 0; r < 2; r++) begin
      for (int k = 7; k >= 0; k--) begin
        note(4'h2, UID[k*8 +: 8]);
      end
      u_host.frame(8'h4B, 1'h0, 1, 0, 32'h0, 32, 1, 8);
    end
    // A powered-down device and an unknown opcode both stay silent.
    for (int j = 0; j < 2; j++) begin
      power_down <= (j == 0);
      st = (j == 0) ? 8'h9F : 8'hC3;
      note(4'h0, 8'h00);
      note(4'h0, 8'h00);
      u_host.frame(st, 1'h0, 1, 0, 32'h0, 0, 1, 2);
    end
    for (int j = 0; j < 3; j++) begin
      st = (j == 0) ? 8'h00 : (j == 1) ? 8'hFE : 8'($urandom);
      for (int k = 0; k < 12; k++) begin
        note(4'h2, tbl(st + 8'(k)));
      end
      u_host.frame(8'h5A, 1'h0, 1, 24, {16'h0, st, 8'h00},
                   8, 1, 12);
    end
    repeat (20) @(posedge clk_sys);
    report_and_stop();
  end
endmodule : test_sfi_id_readout

bind sfi_id_readout sfi_id_readout_assertions u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe), .power_down(power_down),
  .qpi_mode(qpi_mode));
